// ---- rtl/ilo_pkg.sv ----
package ilo_pkg;
  // Instruction encodings (upper bits of the 16-bit word)
  localparam logic [5:0] ADD_OP = 6'h09;
  localparam logic [15:0] ADD_MASK = 16'hFD00;
  localparam logic [15:0] ADD_MATCH = 16'h2400;
  localparam logic [15:0] BSET_MASK = 16'hF100;
  localparam logic [15:0] BSET_MATCH = 16'h8000;
  localparam logic [15:0] SETALL_MASK = 16'hFF00;
  localparam logic [15:0] SETALL_MATCH = 16'h6800;
  localparam int DEST_POS = 9;
  localparam int BSEL_LSB = 9;
  localparam int A_POS = 8;
  localparam logic [7:0] OFFSET_MAX = 8'h5F;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ACCESS_HI_BASE = 8'hF0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  // AXI4-Lite register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_INSN = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_ACC = 4'hC;
  localparam int CTRL_EXT_POS = 0;
  localparam int STAT_N = 4;
  localparam int STAT_OV = 3;
  localparam int STAT_Z = 2;
  localparam int STAT_DC = 1;
  localparam int STAT_C = 0;
  localparam int STAT_BUSY = 8;
  localparam int STAT_LAST_LSB = 12;
  localparam int ACC_POS = 0;
  localparam int FSR_LSB = 8;
  localparam int BSR_LSB = 20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int MEM_DEPTH = 4096;
  typedef enum logic [4:0] {
    ILO_IDLE = 5'h01,
    ILO_Q1 = 5'h02,
    ILO_Q2 = 5'h04,
    ILO_Q3 = 5'h08,
    ILO_Q4 = 5'h10
  } ilo_phase_t;
  typedef enum logic [1:0] {
    ILO_OTHER = 2'h0,
    ILO_ADD = 2'h1,
    ILO_BSET = 2'h2,
    ILO_SETALL = 2'h3
  } ilo_kind_t;
endpackage

// ---- rtl/ilo_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module ilo_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] mem [0:ilo_pkg::MEM_DEPTH-1];
  logic extension_enable_bit;
  logic [11:0] stack_frame_pointer;
  logic [3:0] bank_select_register;
  logic [7:0] acc;
  logic flag_n, flag_ov, flag_z, flag_dc, flag_c;
  logic [15:0] insn;
  logic [1:0] last_kind;
  ilo_pkg::ilo_phase_t phase;
  ilo_pkg::ilo_kind_t kind;
  logic [11:0] ea;
  logic [7:0] opnd;
  logic [7:0] result;
  logic [8:0] sum;
  logic half_c;
  logic aw_hold, w_hold;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic start;
  logic start_wr;

  // Decode of the pending word
  ilo_pkg::ilo_kind_t next_kind;
  logic [11:0] next_ea;
  always_comb begin
    next_kind = ilo_pkg::ILO_OTHER;
    if (extension_enable_bit && insn[7:0] <= ilo_pkg::OFFSET_MAX) begin
      if ((insn & ilo_pkg::ADD_MASK) == ilo_pkg::ADD_MATCH) begin
        next_kind = ilo_pkg::ILO_ADD;
      end else if ((insn & ilo_pkg::BSET_MASK) == ilo_pkg::BSET_MATCH) begin
        next_kind = ilo_pkg::ILO_BSET;
      end else if ((insn & ilo_pkg::SETALL_MASK) == ilo_pkg::SETALL_MATCH) begin
        next_kind = ilo_pkg::ILO_SETALL;
      end
    end
    if (extension_enable_bit && !insn[ilo_pkg::A_POS] && insn[7:0] <= ilo_pkg::OFFSET_MAX) begin
      next_ea = stack_frame_pointer + {4'h0, insn[7:0]};
    end else if (insn[ilo_pkg::A_POS]) begin
      next_ea = {bank_select_register, insn[7:0]};
    end else if (insn[7:0] >= ilo_pkg::ACCESS_HI_BASE) begin
      next_ea = {ilo_pkg::ACCESS_HI_BANK, insn[7:0]};
    end else begin
      next_ea = {4'h0, insn[7:0]};
    end
  end

  // Four-phase instruction cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= ilo_pkg::ILO_IDLE;
    end else begin
      case (phase)
        ilo_pkg::ILO_IDLE: if (start) phase <= ilo_pkg::ILO_Q1;
        ilo_pkg::ILO_Q1: phase <= ilo_pkg::ILO_Q2;
        ilo_pkg::ILO_Q2: phase <= ilo_pkg::ILO_Q3;
        ilo_pkg::ILO_Q3: phase <= ilo_pkg::ILO_Q4;
        default: phase <= ilo_pkg::ILO_IDLE;
      endcase
    end
  end

  // Q1 decode, Q2 read operand
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kind <= ilo_pkg::ILO_OTHER;
      ea <= 12'h000;
      opnd <= 8'h00;
    end else if (phase == ilo_pkg::ILO_Q1) begin
      kind <= next_kind;
      ea <= next_ea;
    end else if (phase == ilo_pkg::ILO_Q2) begin
      opnd <= mem[ea];
    end
  end

  assign sum = {1'b0, acc} + {1'b0, opnd};
  assign half_c = ({1'b0, acc[3:0]} + {1'b0, opnd[3:0]}) > 5'h0F;

  // Q3 process data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= 8'h00;
    end else if (phase == ilo_pkg::ILO_Q3) begin
      case (kind)
        ilo_pkg::ILO_ADD: result <= sum[7:0];
        ilo_pkg::ILO_BSET: result <= opnd | (8'h01 << insn[ilo_pkg::BSEL_LSB +: 3]);
        ilo_pkg::ILO_SETALL: result <= ilo_pkg::ALL_ONES;
        default: result <= opnd;
      endcase
    end
  end

  // Q3 status flags, only for the add form
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_n <= 1'b0;
      flag_ov <= 1'b0;
      flag_z <= 1'b0;
      flag_dc <= 1'b0;
      flag_c <= 1'b0;
    end else if (phase == ilo_pkg::ILO_Q3 && kind == ilo_pkg::ILO_ADD) begin
      flag_n <= sum[7];
      flag_ov <= (acc[7] == opnd[7]) && (sum[7] != acc[7]);
      flag_z <= sum[7:0] == 8'h00;
      flag_dc <= half_c;
      flag_c <= sum[8];
    end
  end

  // Q4 write destination
  always_ff @(posedge clk) begin
    if (phase == ilo_pkg::ILO_Q4) begin
      if (kind == ilo_pkg::ILO_BSET || kind == ilo_pkg::ILO_SETALL) begin
        mem[ea] <= result;
      end else if (kind == ilo_pkg::ILO_ADD && insn[ilo_pkg::DEST_POS]) begin
        mem[ea] <= result;
      end
    end
  end

  // Accumulator: Q4 add with d=0, or software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= 8'h00;
    end else if (phase == ilo_pkg::ILO_Q4 && kind == ilo_pkg::ILO_ADD) begin
      if (!insn[ilo_pkg::DEST_POS]) acc <= result;
    end else if (start_wr && aw_addr == ilo_pkg::REG_ACC && w_strb[0]) begin
      acc <= w_data[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_kind <= 2'h0;
    end else if (phase == ilo_pkg::ILO_Q4) begin
      last_kind <= kind;
    end
  end

  // AXI4-Lite write path
  assign start_wr = aw_hold && w_hold && !s_axi_bvalid;
  assign start = start_wr && aw_addr == ilo_pkg::REG_INSN && phase == ilo_pkg::ILO_IDLE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (start_wr && !(aw_addr == ilo_pkg::REG_INSN && phase != ilo_pkg::ILO_IDLE)) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control, frame pointer, bank select and instruction word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extension_enable_bit <= ilo_pkg::CTRL_RST[ilo_pkg::CTRL_EXT_POS];
      stack_frame_pointer <= 12'h000;
      bank_select_register <= 4'h0;
      insn <= 16'h0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ilo_pkg::RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (start_wr && !(aw_addr == ilo_pkg::REG_INSN && phase != ilo_pkg::ILO_IDLE)) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ilo_pkg::RESP_OKAY;
        if (aw_addr == ilo_pkg::REG_CTRL) begin
          if (w_strb[0]) extension_enable_bit <= w_data[ilo_pkg::CTRL_EXT_POS];
          if (w_strb[1]) stack_frame_pointer[7:0] <= w_data[ilo_pkg::FSR_LSB +: 8];
          if (w_strb[2]) begin
            stack_frame_pointer[11:8] <= w_data[ilo_pkg::FSR_LSB + 8 +: 4];
            bank_select_register <= w_data[ilo_pkg::BSR_LSB +: 4];
          end
        end else if (aw_addr == ilo_pkg::REG_INSN) begin
          if (w_strb[0]) insn[7:0] <= w_data[7:0];
          if (w_strb[1]) insn[15:8] <= w_data[15:8];
        end else if (aw_addr == ilo_pkg::REG_STAT || aw_addr == ilo_pkg::REG_ACC) begin
          s_axi_bresp <= ilo_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= ilo_pkg::RESP_SLVERR;
        end
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ilo_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ilo_pkg::RESP_OKAY;
      if (s_axi_araddr[3:2] == ilo_pkg::REG_CTRL[3:2]) begin
        s_axi_rdata <= {8'h00, bank_select_register, stack_frame_pointer, 7'h00,
          extension_enable_bit};
      end else if (s_axi_araddr[3:2] == ilo_pkg::REG_INSN[3:2]) begin
        s_axi_rdata <= {16'h0000, insn};
      end else if (s_axi_araddr[3:2] == ilo_pkg::REG_STAT[3:2]) begin
        s_axi_rdata <= {18'h00000, last_kind, 3'h0, phase != ilo_pkg::ILO_IDLE, 3'h0,
          flag_n, flag_ov, flag_z, flag_dc, flag_c};
      end else begin
        s_axi_rdata <= {24'h000000, acc};
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- dv/ilo_decode_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module ilo_decode_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:8] s_axi_bvalid) else $error("write answer missing");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_okay: assert property (s_axi_rvalid |-> s_axi_rresp == ilo_pkg::RESP_OKAY)
    else $error("read response not okay");
  a_write_okay: assert property (s_axi_bvalid |-> s_axi_bresp == ilo_pkg::RESP_OKAY)
    else $error("write response not okay");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_write_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_both: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
endmodule
bind ilo_decode ilo_decode_checker chk_u (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- dv/ilo_decode_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module ilo_decode_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] aw = 4'h0, ar = 4'h0, ws = 4'hF;
  logic [31:0] wd = 32'h0, rdat, cr;
  logic awv = 1'b0, awr, wv = 1'b0, wr_rdy, bv, bry = 1'b1;
  logic arv = 1'b0, arr, rv, rry = 1'b1;
  logic [1:0] br, rr;
  logic [7:0] m;
  int bad_count = 0, compares = 0, cyc = 0;
  ilo_decode dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
  always #10 clk = ~clk;
  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    fork
      begin do @(posedge clk); while (!awr); awv <= 1'b0; end
      begin do @(posedge clk); while (!wr_rdy); wv <= 1'b0; end
    join
    do @(posedge clk); while (!bv);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    ar <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    d = rdat;
  endtask
  task automatic ex(input logic [15:0] w);
    logic [31:0] s;
    int n;
    n = 0;
    wr(ilo_pkg::REG_INSN, {16'h0000, w});
    do begin
      rd(ilo_pkg::REG_STAT, s);
      n++;
    end while (s[ilo_pkg::STAT_BUSY] !== 1'b0);
    chk("one cycle", 32'h1, {31'h0, n <= 4});
  endtask
  task automatic st_is(input logic [7:0] a, input logic [4:0] f, input logic [1:0] k);
    logic [31:0] d;
    rd(ilo_pkg::REG_ACC, d);
    chk("acc", {24'h0, a}, {24'h0, d[7:0]});
    rd(ilo_pkg::REG_STAT, d);
    chk("flags", {27'h0, f}, {27'h0, d[4:0]});
    chk("kind", {30'h0, k}, {30'h0, d[13:12]});
  endtask
  // Load acc, add indexed byte into acc, check sum and flags
  task automatic addchk(input logic [7:0] a, input logic [7:0] k, input logic [7:0] e,
    input logic [4:0] f);
    wr(ilo_pkg::REG_ACC, {24'h0, a});
    ex({8'h24, k});
    st_is(e, f, 2'h1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(ilo_pkg::REG_CTRL, cr);
    chk("ctrl reset", ilo_pkg::CTRL_RST, cr);
    st_is(8'h00, 5'h00, 2'h0);
    wr(ilo_pkg::REG_CTRL, 32'h000A_0001);
    ex(16'h682C);
    st_is(8'h00, 5'h00, 2'h3);
    wr(ilo_pkg::REG_ACC, 32'h21);
    ex(16'h262C);
    st_is(8'h21, 5'h03, 2'h1);
    addchk(8'h17, 8'h2C, 8'h37, 5'h00);
    ex(16'h8E2C);
    st_is(8'h37, 5'h00, 2'h2);
    addchk(8'h60, 8'h2C, 8'h00, 5'h05);
    addchk(8'h80, 8'h2C, 8'h20, 5'h09);
    addchk(8'h17, 8'h2C, 8'hB7, 5'h10);
    ex(16'h6810);
    addchk(8'h01, 8'h10, 8'h00, 5'h07);
    wr(ilo_pkg::REG_ACC, 32'h01);
    ex(16'h2610);
    m = 8'h00;
    for (int b = 0; b < 8; b++) begin
      ex({4'h8, b[2:0], 1'b0, 8'h10});
      m = m | (8'h01 << b);
      addchk(8'h00, 8'h10, m, {m[7], 4'h0});
    end
    wr(ilo_pkg::REG_CTRL, 32'h000A_0000);
    ex(16'h682C);
    st_is(8'hFF, 5'h10, 2'h0);
    wr(ilo_pkg::REG_CTRL, 32'h000A_0001);
    addchk(8'h00, 8'h2C, 8'hA0, 5'h10);
    ex(16'h6860);
    st_is(8'hA0, 5'h10, 2'h0);
    wr(ilo_pkg::REG_CTRL, 32'h000F_FF01);
    ex(16'h6820);
    wr(ilo_pkg::REG_CTRL, 32'h0000_0001);
    addchk(8'h00, 8'h1F, 8'hFF, 5'h10);
    tally_and_finish();
  end
endmodule
`default_nettype wire
